// ==== rtl/delay_link_if.sv ====
// Four-wire link between host and delay-setting device
`timescale 1ns/100ps
`default_nettype none
interface delay_link_if;
	logic load_en;    // Load window, high opens shifting
	logic sclk;       // Serial clock
	logic sdin;       // Serial data into device
	logic sdout;      // Serial data out of device
	modport device (input load_en, input sclk, input sdin, output sdout);
	modport host (output load_en, output sclk, output sdin, input sdout);
endinterface
`default_nettype wire

// ==== rtl/delay_pkg.sv ====
// Shared constants for the serial delay-setting link
package delay_pkg;
	localparam int SETTING_WIDTH = 8;
	localparam int TAP_COUNT     = 256;
	localparam logic [7:0] SETTING_RESET = 8'h00;
	localparam logic [7:0] CODE_MIN      = 8'h00;
	localparam logic [7:0] CODE_MAX      = 8'hFF;
	// Core clock rate and serial timing
	localparam int CLK_PERIOD_NS  = 100;
	localparam int SCLK_HALF_NS   = 400;
	localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_US      = 50;
	localparam int SETTLE_CYC     = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CHAIN_DEVICES  = 1;
endpackage

// ==== rtl/delay_setting_dev.sv ====
// Device end: serial setting register with chain output
`timescale 1ns/100ps
`default_nettype none
module delay_setting_dev #(
	parameter int WIDTH = delay_pkg::SETTING_WIDTH
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             reset,
	// Link
	delay_link_if.device          link,
	// Delay setting
	output logic [WIDTH-1:0]      delay_code,
	output logic                  code_update
);
	logic [2:0]       en_sync_reg;
	logic [2:0]       clk_sync_reg;
	logic [1:0]       din_sync_reg;
	logic [WIDTH-1:0] shift_reg;
	logic             sdout_reg;
	logic             sclk_rise;
	logic             window_fall;

	// Two-flop synchronisers; stage 0 is read only by stage 1
	always_ff @(posedge core_clk) begin
		en_sync_reg  <= {en_sync_reg[1:0], link.load_en};
		clk_sync_reg <= {clk_sync_reg[1:0], link.sclk};
		din_sync_reg <= {din_sync_reg[0], link.sdin};
	end

	assign sclk_rise   = clk_sync_reg[1] & ~clk_sync_reg[2];
	assign window_fall = ~en_sync_reg[1] & en_sync_reg[2];

	// Data is synced alongside clock so setup holds after both flops
	always_ff @(posedge core_clk) begin
		if (reset) begin
			shift_reg <= delay_pkg::SETTING_RESET;
		end else if (sclk_rise && en_sync_reg[1]) begin
			shift_reg <= {shift_reg[WIDTH-2:0], din_sync_reg[1]};
		end
	end

	// Output shows the bit that leaves next; it follows a shift in the same
	// edge so the host's readback sees the new bit before its next clock
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sdout_reg <= 1'b0;
		end else if (sclk_rise && en_sync_reg[1]) begin
			sdout_reg <= shift_reg[WIDTH-2];
		end else begin
			sdout_reg <= shift_reg[WIDTH-1];
		end
	end
	assign link.sdout = sdout_reg;

	// Active code changes only when the window closes
	always_ff @(posedge core_clk) begin
		if (reset) begin
			delay_code  <= delay_pkg::SETTING_RESET;
			code_update <= 1'b0;
		end else begin
			code_update <= window_fall;
			if (window_fall) begin
				delay_code <= shift_reg;
			end
		end
	end
endmodule // delay_setting_dev
`default_nettype wire

// ==== rtl/delay_setting_host.sv ====
// Host end: writes or reads settings over the four-wire link
`timescale 1ns/100ps
`default_nettype none
module delay_setting_host #(
	parameter int DEVICES    = delay_pkg::CHAIN_DEVICES,
	parameter int SETTLE_CYC = delay_pkg::SETTLE_CYC
) (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	// Link
	delay_link_if.host                 link,
	// User request
	input  wire logic                  start,
	input  wire logic                  read_mode,
	input  wire logic [DEVICES*8-1:0]  wr_data,
	// User answer
	output logic                       busy,
	output logic                       done,
	output logic [DEVICES*8-1:0]       rd_data
);
	localparam int NBITS = DEVICES * delay_pkg::SETTING_WIDTH;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_LOW    = 3'b001,
		ST_HIGH   = 3'b010,
		ST_CLOSE  = 3'b011,
		ST_SETTLE = 3'b100
	} state_t;
	state_t           state_reg;
	logic [NBITS-1:0] data_reg;
	logic [NBITS-1:0] cap_reg;
	logic             rd_reg;
	logic [15:0]      bit_cnt_reg;
	logic [19:0]      tick_reg;
	logic [1:0]       q_sync_reg;
	logic             en_reg;
	logic             sclk_reg;
	logic             sdin_reg;

	always_ff @(posedge core_clk) begin
		q_sync_reg <= {q_sync_reg[0], link.sdout};
	end

	// Sequencer: half periods of the serial clock, then settle wait
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg   <= ST_IDLE;
			en_reg      <= 1'b0;
			sclk_reg    <= 1'b0;
			sdin_reg    <= 1'b0;
			busy        <= 1'b0;
			done        <= 1'b0;
			rd_reg      <= 1'b0;
			data_reg    <= '0;
			cap_reg     <= '0;
			rd_data     <= '0;
			bit_cnt_reg <= '0;
			tick_reg    <= '0;
		end else begin
			done <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						busy        <= 1'b1;
						rd_reg      <= read_mode;
						data_reg    <= wr_data;
						en_reg      <= 1'b1;
						bit_cnt_reg <= 16'(NBITS);
						tick_reg    <= 20'(delay_pkg::SCLK_HALF_CYC);
						state_reg   <= ST_LOW;
					end
				end
				ST_LOW: begin
					if (tick_reg == 20'h00001) begin
						// Readback returns the observed bit to keep the setting
						sdin_reg <= rd_reg ? q_sync_reg[1] : data_reg[NBITS-1];
						cap_reg  <= {cap_reg[NBITS-2:0], q_sync_reg[1]};
						data_reg <= {data_reg[NBITS-2:0], 1'b0};
						tick_reg <= 20'(delay_pkg::SCLK_HALF_CYC);
						state_reg <= ST_HIGH;
					end else begin
						tick_reg <= tick_reg - 20'h00001;
					end
				end
				ST_HIGH: begin
					// Rise early enough that the pulse stands two core cycles
					if (tick_reg == 20'(delay_pkg::SCLK_HALF_CYC / 2 + 1)) begin
						sclk_reg <= 1'b1;
					end
					if (tick_reg == 20'h00001) begin
						sclk_reg    <= 1'b0;
						bit_cnt_reg <= bit_cnt_reg - 16'h0001;
						tick_reg    <= 20'(delay_pkg::SCLK_HALF_CYC);
						state_reg   <= (bit_cnt_reg == 16'h0001) ? ST_CLOSE : ST_LOW;
					end else begin
						tick_reg <= tick_reg - 20'h00001;
					end
				end
				ST_CLOSE: begin
					if (tick_reg == 20'h00001) begin
						en_reg    <= 1'b0;
						tick_reg  <= 20'(SETTLE_CYC);
						state_reg <= ST_SETTLE;
					end else begin
						tick_reg <= tick_reg - 20'h00001;
					end
				end
				ST_SETTLE: begin
					if (tick_reg == 20'h00001) begin
						busy      <= 1'b0;
						done      <= 1'b1;
						rd_data   <= cap_reg;
						state_reg <= ST_IDLE;
					end else begin
						tick_reg <= tick_reg - 20'h00001;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign link.load_en = en_reg;
	assign link.sclk    = sclk_reg;
	assign link.sdin    = sdin_reg;
endmodule // delay_setting_host
`default_nettype wire

// ==== verif/delay_link_props.sv ====
// Link-level assertions for the delay-setting link
`timescale 1ns/100ps
`default_nettype none
module delay_link_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Link
	input wire logic load_en,
	input wire logic sclk,
	input wire logic sdin,
	input wire logic sdout
);
	logic       sclk_reg;
	logic [4:0] edge_reg;
	// Previous serial clock level
	always_ff @(posedge core_clk) sclk_reg <= sclk;
	// Rising serial edges in the open window
	always_ff @(posedge core_clk) begin
		if (reset || !load_en) edge_reg <= 5'h00;
		else if (sclk && !sclk_reg) edge_reg <= edge_reg + 5'h01;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence bit_rise; load_en && $rose(sclk); endsequence
	sequence window_end; $fell(load_en); endsequence
	bit_count_a: assert property (window_end |-> edge_reg == 5'h08)
		else $error("bit count at close wrong");
	shift_gate_a: assert property (!load_en [*4] |=> $stable(sdout))
		else $error("output moved while closed");
	out_moves_a: assert property ($changed(sdout) |-> $past(load_en, 2))
		else $error("output moved outside window");
	idle_clk_a: assert property (!load_en |-> !sclk)
		else $error("clock high while closed");
	open_quiet_a: assert property ($rose(load_en) |-> !sclk ##1 !sclk)
		else $error("clock high at open");
	close_quiet_a: assert property (window_end |-> !sclk)
		else $error("clock high at close");
	data_hold_a: assert property (bit_rise |-> $stable(sdin) [*2])
		else $error("data moved at clock rise");
	clk_width_a: assert property (bit_rise |-> sclk [*2])
		else $error("clock pulse too short");
endmodule // delay_link_props
`default_nettype wire

// ==== verif/serial_delay_setting_register_tb_top.sv ====
// Bench joining host and device ends
`timescale 1ns/100ps
`default_nettype none
module serial_delay_setting_register_tb_top;
	logic       core_clk = 1'b0;
	logic       reset = 1'b1;
	logic       start = 1'b0;
	logic       read_mode = 1'b0;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] rd_data;
	logic [7:0] delay_code;
	logic       busy;
	logic       done;
	logic       code_update;
	int         err_count = 0;
	int         checks = 0;
	int         upd = 0;
	delay_link_if link ();
	delay_setting_dev i_delay_setting_dev (.core_clk(core_clk), .reset(reset), .link(link),
		.delay_code(delay_code), .code_update(code_update));
	delay_setting_host #(.DEVICES(1), .SETTLE_CYC(4)) i_delay_setting_host (
		.core_clk(core_clk), .reset(reset), .link(link), .start(start),
		.read_mode(read_mode), .wr_data(wr_data), .busy(busy), .done(done), .rd_data(rd_data));
	delay_link_props i_delay_link_props (.core_clk(core_clk), .reset(reset),
		.load_en(link.load_en), .sclk(link.sclk), .sdin(link.sdin), .sdout(link.sdout));
	initial forever #50 core_clk = ~core_clk;
	// Count setting updates per frame
	always @(posedge core_clk) if (code_update === 1'b1) upd <= upd + 1;
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One host frame, bounded wait for done
	task automatic frame(input logic rm, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		#1;
		upd = 0;
		read_mode = rm;
		wr_data = d;
		start = 1'b1;
		@(posedge core_clk);
		#1;
		start = 1'b0;
		cmp("busy", 8'h01, {7'h00, busy});
		while (done !== 1'b1 && n < 300) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 300) cmp("done", 8'h01, 8'h00);
		cmp("idle", 8'h00, {7'h00, busy});
	endtask
	task automatic write_extremes;
		frame(1'b0, 8'hFF);
		cmp("code max", 8'hFF, delay_code);
		cmp("updates", 8'h01, 8'(upd));
		frame(1'b0, 8'h00);
		cmp("code min", 8'h00, delay_code);
	endtask
	task automatic write_order;
		frame(1'b0, 8'h1E);
		cmp("code order", 8'h1E, delay_code);
	endtask
	task automatic read_keep;
		frame(1'b1, 8'hFF);
		cmp("readback", 8'h1E, rd_data);
		cmp("code kept", 8'h1E, delay_code);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Watchdog well beyond four frames
	initial begin
		#200000;
		err_count++;
		give_verdict;
	end
	initial begin
		repeat (16) @(posedge core_clk);
		#1;
		reset = 1'b0;
		write_extremes;
		write_order;
		read_keep;
		give_verdict;
	end
endmodule // serial_delay_setting_register_tb_top
`default_nettype wire
